// ==== logic/sss_pkg.sv ====
// shared constants, types and decoders of the serial port status bank
package sss_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register byte addresses on the wishbone bus
  localparam logic [7:0] ADR_CTRL = 8'h90;
  localparam logic [7:0] ADR_STATUS = 8'h94;
  localparam logic [7:0] ADR_DATA = 8'h98;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h9C;
  localparam logic [7:0] ADR_IRQ_MASK = 8'hA0;
  localparam logic [7:0] ADR_SLAVE_ADDR = 8'hA4;

  ////////////////////////////////////////////////////////////////////////
  // status register fields
  localparam int ST_SAMPLE = 7;
  localparam int ST_EDGE = 6;
  localparam int ST_DATA_ADDR = 5;
  localparam int ST_STOP = 4;
  localparam int ST_START = 3;
  localparam int ST_RW = 2;
  localparam int ST_UA = 1;
  localparam int ST_BF = 0;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // control register fields
  localparam int CT_EN = 5;
  localparam int CT_CKP = 4;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // interrupt status and mask fields
  localparam int IRQ_BYTE = 0;
  localparam int IRQ_START = 1;
  localparam int IRQ_STOP = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [7:0] SADDR_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // master half bit periods in system clocks, one per master mode
  localparam logic [5:0] HALF_DIV4 = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  localparam logic [5:0] HALF_TMR = 6'h3F;

  typedef enum logic [3:0] {
    MODE_SPI_M_4 = 4'h0,
    MODE_SPI_M_16 = 4'h1,
    MODE_SPI_M_64 = 4'h2,
    MODE_SPI_M_TMR = 4'h3,
    MODE_SPI_S_SS = 4'h4,
    MODE_SPI_S = 4'h5,
    MODE_I2C_7 = 4'h6,
    MODE_I2C_10 = 4'h7,
    MODE_I2C_FW = 4'hB,
    MODE_I2C_7_SP = 4'hE,
    MODE_I2C_10_SP = 4'hF
  } sss_mode_e;

  // events from the i2c engine, same clock domain, one-cycle pulses
  typedef struct packed {
    logic start;
    logic stop;
    logic addr_match;
    logic rw;
    logic byte_done;
    logic is_data;
    logic tx_done;
    logic ua_set;
    logic [7:0] rx_byte;
  } sss_i2c_ev_s;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic is_spi_master(input logic [3:0] m);
    return m[3:2] == 2'b00;
  endfunction

  function automatic logic is_spi_slave(input logic [3:0] m);
    return (m == MODE_SPI_S_SS) || (m == MODE_SPI_S);
  endfunction

  function automatic logic is_i2c(input logic [3:0] m);
    return (m == MODE_I2C_7) || (m == MODE_I2C_10) || (m == MODE_I2C_FW) ||
      (m == MODE_I2C_7_SP) || (m == MODE_I2C_10_SP);
  endfunction

  function automatic logic is_ten_bit(input logic [3:0] m);
    return (m == MODE_I2C_10) || (m == MODE_I2C_10_SP);
  endfunction

  function automatic logic [5:0] half_div(input logic [3:0] m);
    case (m[1:0])
      2'b00: return HALF_DIV4;
      2'b01: return HALF_DIV16;
      2'b10: return HALF_DIV64;
      default: return HALF_TMR;
    endcase
  endfunction

endpackage

// ==== logic/sss_sync_edge.sv ====
// two-flop synchroniser with edge detection for pin inputs
`timescale 1ns/100ps
module sss_sync_edge #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // raw pins and synchronised results
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] prev;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("sss_sync_edge needs WIDTH of at least 1");
  end

  // only the second stage and later are looked at
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end
    else
    begin
      meta <= async_i;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level_o = sync;
  assign rise_o = sync & ~prev;
  assign fall_o = ~sync & prev;
endmodule // sss_sync_edge

// ==== logic/sss_status_bank.sv ====
// serial port status bank with spi shift timing and i2c status flags
`timescale 1ns/100ps
module sss_status_bank (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // spi pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  input wire logic ss_n_i,
  // i2c engine side
  input wire sss_pkg::sss_i2c_ev_s i2c_ev_i,
  output logic [7:0] i2c_tx_byte_o,
  output logic [7:0] slave_address_o,
  // interrupt
  output logic irq_o
);
  import sss_pkg::*;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic ack;
  logic [5:0] ctrl;
  logic input_sample_phase;
  logic cke;
  logic data_addr;
  logic stop_f;
  logic start_f;
  logic rw_f;
  logic ua_f;
  logic bf;
  logic [7:0] rx_buf;
  logic [7:0] tx_hold;
  logic [7:0] tx_sr;
  logic [7:0] rx_sr;
  logic [7:0] saddr;
  logic out_bit;
  logic busy;
  logic half;
  logic [5:0] div;
  logic [2:0] bit_cnt;
  logic [2:0] rx_cnt;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [31:0] next_rdata;
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: bit 0 sck, bit 1 sdi, bit 2 ss_n
  sss_sync_edge #(
    .WIDTH(3)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({ss_n_i, sdi_i, sck_i}),
    .level_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  logic acc;
  logic wr;
  logic rd;
  assign acc = wb_cyc_i & wb_stb_i & ~ack;
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign rd = acc & ~wb_we_i;

  logic wr_ctrl;
  logic wr_status;
  logic wr_data;
  logic rd_data;
  logic wr_istat;
  logic wr_imask;
  logic wr_saddr;
  assign wr_ctrl = wr && wb_adr_i == ADR_CTRL;
  assign wr_status = wr && wb_adr_i == ADR_STATUS;
  assign wr_data = wr && wb_adr_i == ADR_DATA;
  assign rd_data = rd && wb_adr_i == ADR_DATA;
  assign wr_istat = wr && wb_adr_i == ADR_IRQ_STAT;
  assign wr_imask = wr && wb_adr_i == ADR_IRQ_MASK;
  assign wr_saddr = wr && wb_adr_i == ADR_SLAVE_ADDR;

  // mode decode
  logic [3:0] mode;
  logic en;
  logic clock_idle_polarity;
  logic m_on;
  logic s_mode;
  logic s_on;
  logic spi_on;
  logic i2c_on;
  assign mode = ctrl[3:0];
  assign en = ctrl[CT_EN];
  assign clock_idle_polarity = ctrl[CT_CKP];
  assign m_on = en & is_spi_master(mode);
  assign s_mode = en & is_spi_slave(mode);
  // ss_n high pauses the slave mid byte instead of resetting it
  assign s_on = s_mode & ((mode != MODE_SPI_S_SS) | ~pin_lvl[2]);
  assign spi_on = m_on | s_mode;
  assign i2c_on = en & is_i2c(mode);

  ////////////////////////////////////////////////////////////////////////
  // shift timing: a bit is two half periods; output changes at bit edges
  logic tick;
  logic sample_m;
  logic launch_m;
  logic sample_s;
  logic launch_s;
  logic sample;
  logic launch;
  logic byte_spi;
  logic load;
  assign tick = busy && div == half_div(mode) - 6'd1;
  assign sample_m = tick & (half ? input_sample_phase : ~input_sample_phase);
  assign launch_m = tick && half && bit_cnt != 3'd7;
  // slave launches on the rising edge when edge bit and polarity differ
  assign sample_s = s_on & ((cke ^ clock_idle_polarity) ? pin_fall[0] : pin_rise[0]);
  assign launch_s = s_on && ((cke ^ clock_idle_polarity) ? pin_rise[0] : pin_fall[0]) && rx_cnt != 3'd0;
  assign sample = sample_m | sample_s;
  assign launch = launch_m | launch_s;
  assign byte_spi = sample && rx_cnt == 3'd7;
  assign load = wr_data & ((m_on & ~busy) | (s_mode & (rx_cnt == 3'd0)));

  // master bit engine; a write while busy is dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !m_on)
    begin
      busy <= 1'b0;
      half <= 1'b0;
      div <= 6'h00;
      bit_cnt <= 3'h0;
    end
    else if (load)
    begin
      busy <= 1'b1;
      half <= 1'b0;
      div <= 6'h00;
      bit_cnt <= 3'h0;
    end
    else if (tick)
    begin
      div <= 6'h00;
      half <= ~half;
      if (half)
      begin
        bit_cnt <= bit_cnt + 3'd1;
        busy <= bit_cnt != 3'd7;
      end
    end
    else if (busy)
    begin
      div <= div + 6'd1;
    end
  end

  // receive shifter, msb first
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !spi_on)
    begin
      rx_cnt <= 3'h0;
      rx_sr <= 8'h00;
    end
    else if (sample)
    begin
      rx_cnt <= rx_cnt + 3'd1;
      rx_sr <= {rx_sr[6:0], pin_lvl[1]};
    end
  end

  // transmit shifter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_bit <= 1'b0;
      tx_sr <= 8'h00;
    end
    else if (load)
    begin
      out_bit <= wb_dat_i[7];
      tx_sr <= {wb_dat_i[6:0], 1'b0};
    end
    else if (launch)
    begin
      out_bit <= tx_sr[7];
      tx_sr <= {tx_sr[6:0], 1'b0};
    end
  end

  assign sdo_o = out_bit;
  assign sdo_oe_o = m_on | s_on;
  // clock is active in the first half when edge bit is 1, else second
  assign sck_o = clock_idle_polarity ^ (busy & (half ^ cke));
  assign sck_oe_o = m_on;

  ////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= CTRL_RST;
      irq_mask <= IRQ_RST;
      saddr <= SADDR_RST;
      tx_hold <= 8'h00;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= wb_dat_i[5:0];
      if (wr_imask)
        irq_mask <= wb_dat_i[IRQ_W-1:0];
      if (wr_saddr)
        saddr <= wb_dat_i[7:0];
      if (wr_data)
        tx_hold <= wb_dat_i[7:0];
    end
  end

  // only the two phase bits take writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      input_sample_phase <= STATUS_RST[ST_SAMPLE];
      cke <= STATUS_RST[ST_EDGE];
    end
    else if (wr_status)
    begin
      input_sample_phase <= wb_dat_i[ST_SAMPLE];
      cke <= wb_dat_i[ST_EDGE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // i2c status flags
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !en)
    begin
      start_f <= 1'b0;
      stop_f <= 1'b0;
    end
    else if (i2c_on && i2c_ev_i.start)
    begin
      start_f <= 1'b1;
      stop_f <= 1'b0;
    end
    else if (i2c_on && i2c_ev_i.stop)
    begin
      stop_f <= 1'b1;
      start_f <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      data_addr <= 1'b0;
    else if (i2c_on && i2c_ev_i.byte_done)
      data_addr <= i2c_ev_i.is_data;
    else if (i2c_on && i2c_ev_i.tx_done)
      data_addr <= 1'b1;
  end

  // held after the match; only meaningful up to the next bus event
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rw_f <= 1'b0;
    else if (i2c_on && i2c_ev_i.addr_match)
      rw_f <= i2c_ev_i.rw;
  end

  // set wins over the clear made by rewriting the address
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ua_f <= 1'b0;
    else if (i2c_on && is_ten_bit(mode) && i2c_ev_i.ua_set)
      ua_f <= 1'b1;
    else if (wr_saddr || !(i2c_on && is_ten_bit(mode)))
      ua_f <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // receive buffer and buffer full; a new byte beats a clearing read
  logic i2c_byte;
  logic bf_set;
  logic bf_clr;
  assign i2c_byte = i2c_on & i2c_ev_i.byte_done;
  assign bf_set = byte_spi | i2c_byte | (i2c_on & wr_data);
  assign bf_clr = rd_data | (i2c_on & i2c_ev_i.tx_done);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bf <= 1'b0;
    else if (bf_set)
      bf <= 1'b1;
    else if (bf_clr)
      bf <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_buf <= 8'h00;
    else if (byte_spi)
      rx_buf <= {rx_sr[6:0], pin_lvl[1]};
    else if (i2c_byte)
      rx_buf <= i2c_ev_i.rx_byte;
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, write one to clear, set wins
  logic [2:0] irq_set;
  assign irq_set = {i2c_on & i2c_ev_i.stop, i2c_on & i2c_ev_i.start, byte_spi | i2c_byte};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat <= IRQ_RST;
    else
      irq_stat <= (irq_stat & ~(wr_istat ? wb_dat_i[IRQ_W-1:0] : 3'h0)) | irq_set;
  end

  assign irq_o = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // bus answer, one wait state; unmapped reads give zero
  logic [7:0] status;
  assign status = {input_sample_phase, cke, data_addr, stop_f, start_f, rw_f, ua_f, bf};

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      ADR_CTRL: next_rdata[5:0] = ctrl;
      ADR_STATUS: next_rdata[7:0] = status;
      ADR_DATA: next_rdata[7:0] = rx_buf;
      ADR_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
      ADR_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
      ADR_SLAVE_ADDR: next_rdata[7:0] = saddr;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack <= acc;
      if (rd)
        wb_dat_o <= next_rdata;
    end
  end

  assign wb_ack_o = ack;
  assign i2c_tx_byte_o = tx_hold;
  assign slave_address_o = saddr;

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_idle_level: assert property (m_on && !busy |-> sck_o == clock_idle_polarity)
    else $error("master clock not at idle level");
  chk_sample_point: assert property (sample_m |-> ##1 rx_cnt == $past(rx_cnt) + 3'd1
    && (half == !input_sample_phase))
    else $error("master sample point wrong for phase bit");
  chk_mid_sample: assert property (tick && !half && !input_sample_phase && m_on |-> sample)
    else $error("mid bit sample missing");
  chk_launch_edge: assert property (m_on && busy && $past(busy) && $changed(sdo_o)
    |-> $changed(sck_o) && sck_o == (clock_idle_polarity ^ cke))
    else $error("master data launched on wrong clock edge");
  chk_slave_launch: assert property (launch_s |-> (cke ^ clock_idle_polarity) == pin_rise[0])
    else $error("slave data launched on wrong clock edge");
  chk_data_addr: assert property (i2c_byte |=> data_addr == $past(i2c_ev_i.is_data))
    else $error("data address flag wrong");
  chk_stop_flag: assert property (i2c_on && i2c_ev_i.start && en |=> !stop_f && start_f)
    else $error("stop flag not cleared by start");
  chk_start_flag: assert property (i2c_on && i2c_ev_i.stop && !i2c_ev_i.start && en
    |=> !start_f && stop_f)
    else $error("start flag not cleared by stop");
  chk_rw_capture: assert property (i2c_on && i2c_ev_i.addr_match |=> rw_f == $past(i2c_ev_i.rw))
    else $error("direction not captured");
  chk_ua_set: assert property (i2c_on && is_ten_bit(mode) && i2c_ev_i.ua_set |=> ua_f)
    else $error("update address flag not set");
  chk_byte_full: assert property (byte_spi |=> bf && irq_stat[IRQ_BYTE] && rx_cnt == 3'd0)
    else $error("received byte did not fill buffer");
  chk_read_clear: assert property (rd_data && !bf_set |=> !bf)
    else $error("buffer read did not clear full flag");
  chk_status_ro: assert property (wr_status |=> status[5:0] == $past(status[5:0])
    || $past(bf_set || bf_clr || i2c_on || !en))
    else $error("read-only status bit took a write");
endmodule // sss_status_bank

// ==== bench/sss_spi_partner.sv ====
// far-side spi device model that shifts one byte against the port clock
`timescale 1ns/100ps
module sss_spi_partner (
  // bench controls
  input wire logic clk_i,
  input wire logic clear_i,
  input wire logic cke_i,
  input wire logic late_i,
  input wire logic [7:0] tx_i,
  output logic [7:0] rx_o,
  // link pins
  input wire logic sck_i,
  input wire logic sdo_i,
  output logic sdi_o
);
  logic [4:0] edges = 5'h00;
  logic [4:0] k;
  logic cur;
  logic [3:0] dly = 4'h0;
  ////////////////////////////////////////////////////////////////////////
  // msb first; with edge bit 0 the first bit already stands before the first edge
  always_comb
  begin
    k = edges - 5'(cke_i && edges != 5'h00);
    cur = (k[4:1] > 4'h7) ? tx_i[0] : tx_i[3'h7 - k[3:1]];
  end
  // the bit holds only in the chosen half of its period and is inverted in the other,
  // so a sampler at the wrong point reads garbage; 4 clocks of output delay
  always @(posedge clk_i)
    dly <= {dly[2:0], ((edges[0] ^ cke_i) == late_i) ? cur : ~cur};
  assign sdi_o = dly[3];
  ////////////////////////////////////////////////////////////////////////
  // launch and capture on opposite edges; edge count saturates at one byte
  always @(sck_i or posedge clear_i)
  begin
    if (clear_i)
    begin
      edges = 5'h00;
      rx_o = 8'h00;
    end
    else if (edges < 5'h10)
    begin
      edges = edges + 5'h01;
      if (edges[0] ^ cke_i)
        rx_o = {rx_o[6:0], sdo_i};
    end
  end
endmodule // sss_spi_partner

// ==== bench/sss_status_bank_bench.sv ====
// self-checking bench of the serial port status bank
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("FAIL t=%0t got %h exp %h", $time, got, exp); end end
module sss_status_bank_bench;
  import sss_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic sck_i = 1'b0;
  logic sck_o;
  logic sck_oe;
  logic sck_w;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  sss_i2c_ev_s i2c_ev = '0;
  logic [7:0] tx_byte;
  logic [7:0] saddr;
  logic irq;
  logic clear = 1'b0;
  logic cke = 1'b0;
  logic late = 1'b0;
  logic [7:0] ptx = 8'h00;
  logic [7:0] prx;
  int fails = 0;
  int num_checks = 0;
  int seed = 32'h8e70;
  logic [31:0] rnd;
  logic [7:0] s;
  // i2c data/address and direction flags keep their last value outside i2c modes
  logic keep_da = 1'b0;
  logic keep_rw = 1'b0;
  logic [7:0] regs [6] = '{ADR_CTRL, ADR_STATUS, ADR_IRQ_STAT, ADR_IRQ_MASK, ADR_SLAVE_ADDR,
    8'h80};

  sss_status_bank u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .sck_i(sck_i), .sck_o(sck_o), .sck_oe_o(sck_oe), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .ss_n_i(1'b0), .i2c_ev_i(i2c_ev), .i2c_tx_byte_o(tx_byte),
    .slave_address_o(saddr), .irq_o(irq)
  );
  sss_spi_partner u_partner (
    .clk_i(clk_i), .clear_i(clear), .cke_i(cke), .late_i(late), .tx_i(ptx), .rx_o(prx),
    .sck_i(sck_w), .sdo_i(sdo), .sdi_o(sdi)
  );
  // the partner follows whichever side drives the link clock
  assign sck_w = sck_oe ? sck_o : sck_i;
  always #4 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= {24'h00_0000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 64);
    q = wb_rdat[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 64)
    begin
      fails++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    wb(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    wb(1'b0, a, 8'h00, q);
  endtask

  // one-cycle event pulse from the i2c engine: flags msb first, then the byte
  task automatic ev(input logic [7:0] flags, input logic [7:0] b);
    @(posedge clk_i);
    i2c_ev <= sss_i2c_ev_s'({flags, b});
    @(posedge clk_i);
    i2c_ev <= '0;
  endtask

  function automatic logic [7:0] spi_st(input logic input_sample_phase, input logic kce, input logic bf);
    return {input_sample_phase, kce, keep_da, 2'b00, keep_rw, 1'b0, bf};
  endfunction

  task automatic wait_bf();
    int n;
    n = 0;
    do
    begin
      rd(ADR_STATUS, s);
      n++;
    end
    while (s[ST_BF] !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      fails++;
      give_verdict();
    end
  endtask

  task automatic spi_byte(input logic master, input logic [3:0] mode, input logic clock_idle_polarity,
    input logic kce, input logic input_sample_phase);
    logic [7:0] d;
    d = 8'($random(seed));
    wr(ADR_CTRL, 8'h00);
    sck_i <= clock_idle_polarity;
    cke <= kce;
    late <= input_sample_phase;
    ptx <= 8'($random(seed));
    wr(ADR_STATUS, {input_sample_phase, kce, 6'h00});
    wr(ADR_CTRL, {3'h1, clock_idle_polarity, mode});
    // reconfiguring may move the clock pin, so the partner restarts its count
    @(posedge clk_i);
    clear <= 1'b1;
    @(posedge clk_i);
    clear <= 1'b0;
    if (master)
      `CHK(sck_o, clock_idle_polarity)
    `CHK({sck_oe, sdo_oe}, {master, 1'b1})
    wr(ADR_DATA, d);
    rd(ADR_STATUS, s);
    `CHK(s, spi_st(input_sample_phase, kce, 1'b0))
    // link clock of 160 ns, changed right after a system clock edge
    if (!master)
    begin
      repeat (16)
      begin
        repeat (10) @(posedge clk_i);
        sck_i <= ~sck_i;
      end
    end
    wait_bf();
    `CHK(irq, 1'b1)
    rd(ADR_DATA, s);
    `CHK(s, ptx)
    `CHK(prx, d)
    rd(ADR_STATUS, s);
    `CHK(s, spi_st(input_sample_phase, kce, 1'b0))
    wr(ADR_IRQ_STAT, 8'h01);
    @(posedge clk_i);
    `CHK(irq, 1'b0)
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (regs[j])
    begin
      rd(regs[j], s);
      `CHK(s, 8'h00)
    end
    `CHK({irq, sck_o}, 2'b00)
    wr(ADR_STATUS, 8'hFF);
    rd(ADR_STATUS, s);
    `CHK(s, spi_st(1'b1, 1'b1, 1'b0))
    wr(8'h80, 8'h5A);
    rd(8'h80, s);
    `CHK(s, 8'h00)
    // i2c ten-bit slave: flags follow the engine's events
    wr(ADR_IRQ_MASK, 8'h07);
    wr(ADR_STATUS, 8'h00);
    wr(ADR_CTRL, {3'h1, 1'b0, 4'(MODE_I2C_10)});
    repeat (3)
    begin
      rnd = $random(seed);
      ev(8'h80, 8'h00);
      rd(ADR_STATUS, s);
      `CHK(s[4:3], 2'b01)
      ev({3'h1, rnd[0], 4'h0}, 8'h00);
      rd(ADR_STATUS, s);
      `CHK(s[ST_RW], rnd[0])
      keep_rw = rnd[0];
      ev({4'h0, 1'b1, rnd[1], 2'h0}, rnd[15:8]);
      rd(ADR_STATUS, s);
      `CHK({s[ST_DATA_ADDR], s[ST_BF]}, {rnd[1], 1'b1})
      wr(ADR_IRQ_MASK, 8'h00);
      @(posedge clk_i);
      `CHK(irq, 1'b0)
      wr(ADR_IRQ_MASK, 8'h07);
      @(posedge clk_i);
      `CHK(irq, 1'b1)
      rd(ADR_DATA, s);
      `CHK(s, rnd[15:8])
      rd(ADR_STATUS, s);
      `CHK(s[ST_BF], 1'b0)
      ev(8'h01, 8'h00);
      rd(ADR_STATUS, s);
      `CHK(s[ST_UA], 1'b1)
      wr(ADR_SLAVE_ADDR, rnd[23:16]);
      rd(ADR_STATUS, s);
      `CHK({s[ST_UA], saddr}, {1'b0, rnd[23:16]})
      wr(ADR_DATA, rnd[31:24]);
      rd(ADR_STATUS, s);
      `CHK({s[ST_BF], tx_byte}, {1'b1, rnd[31:24]})
      ev(8'h02, 8'h00);
      rd(ADR_STATUS, s);
      `CHK({s[ST_DATA_ADDR], s[ST_BF]}, 2'b10)
      keep_da = 1'b1;
      ev(8'h40, 8'h00);
      rd(ADR_STATUS, s);
      `CHK(s[4:3], 2'b10)
      wr(ADR_IRQ_STAT, 8'h07);
    end
    ev(8'h80, 8'h00);
    wr(ADR_CTRL, 8'h00);
    rd(ADR_STATUS, s);
    `CHK(s[4:3], 2'b00)
    // the closing start left its interrupt bit set
    wr(ADR_IRQ_STAT, 8'h07);
    `CHK(irq, 1'b0)
    // master: every polarity, edge and sample point, the slowest rate last
    for (int i = 0; i < 8; i++)
    begin
      rnd = $random(seed);
      spi_byte(1'b1, (i == 7) ? 4'h3 : (rnd[0] ? 4'h2 : 4'h1), i[0], i[1], i[2]);
    end
    // slave: link clock from the bench, sample phase kept at zero
    for (int i = 0; i < 4; i++)
    begin
      rnd = $random(seed);
      spi_byte(1'b0, rnd[0] ? 4'h5 : 4'h4, i[0], i[1], 1'b0);
    end
    give_verdict();
  end
endmodule // sss_status_bank_bench
